/* File: rtl/reset_source_ctrl.sv */
// Reset-source controller with APB registers and watchdog
`timescale 1ns/1ns
`include "rst_params.svh"
module reset_source_ctrl import rst_pkg::*; #(
    parameter int unsigned WDT_SHIFT_BASE = `WDT_SHIFT_BASE
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Reset sources
    input wire logic ext_reset_n,
    input wire logic comparator_out,
    input wire logic conversion_start_input,
    input wire logic missing_clock_in,
    // System outputs
    output logic sys_reset_n,
    output logic irq
);
    // --------------------------------------------------------------
    // Declarations
    // --------------------------------------------------------------
    wdt_if wdt_link ();
    logic [3:0] async_in;
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic pin_low;
    logic cmp_low;
    logic cnv_low;
    logic mcd_hit;
    logic cmp_arm_r;
    logic cnv_arm_r;
    logic mcd_en_r;
    logic [7:0] src_now;
    logic any_src;
    seq_state_type state_r;
    seq_state_type state_nxt;
    logic [3:0] stretch_r;
    logic [7:0] cause_r;
    logic [7:0] flags_r;
    logic sys_rst_n_r;
    logic [7:0] irq_stat_r;
    logic [7:0] irq_en_r;
    logic irq_r;
    logic setup_ph;
    logic wr_acc;
    logic [31:0] rd_mux;
    logic addr_ok;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic release_ev;
    logic [7:0] wdt_rd;

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign sys_reset_n = sys_rst_n_r;
    assign irq = irq_r;

    // --------------------------------------------------------------
    // Input synchronisers
    // --------------------------------------------------------------
    assign async_in = {missing_clock_in, conversion_start_input, comparator_out, ext_reset_n};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_r[gi] <= 1'(`SYNC_RESET_VAL >> gi);
                    sync2_r[gi] <= 1'(`SYNC_RESET_VAL >> gi);
                end else begin
                    sync1_r[gi] <= async_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    assign pin_low = !sync2_r[0];
    assign cmp_low = !sync2_r[1];
    assign cnv_low = !sync2_r[2];
    assign mcd_hit = sync2_r[3];

    // --------------------------------------------------------------
    // Source combination
    // --------------------------------------------------------------
    // Only a request into the sequencer; the reset pin is input only
    always_comb begin
        src_now = 8'h00;
        src_now[`BIT_PIN_FLAG] = pin_low;
        src_now[`BIT_MCD_FLAG] = mcd_en_r && mcd_hit;
        src_now[`BIT_WDT_FLAG] = wdt_link.overflow;
        src_now[`BIT_CMP_FLAG] = cmp_arm_r && cmp_low;
        src_now[`BIT_CNV_FLAG] = cnv_arm_r && cnv_low;
    end

    assign any_src = |src_now;

    // --------------------------------------------------------------
    // Reset sequencer
    // --------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_RUN: begin
                if (any_src) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!any_src) begin
                    state_nxt = ST_STRETCH;
                end
            end
            ST_STRETCH: begin
                if (any_src) begin
                    state_nxt = ST_HOLD;
                end else if (stretch_r == 4'(`RST_STRETCH_CYC - 1)) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stretch_r <= 4'h0;
        end else if (state_r == ST_STRETCH && !any_src) begin
            stretch_r <= stretch_r + 4'h1;
        end else begin
            stretch_r <= 4'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_rst_n_r <= 1'b0;
        end else begin
            sys_rst_n_r <= (state_nxt == ST_RUN);
        end
    end

    assign release_ev = (state_r == ST_STRETCH) && (state_nxt == ST_RUN);

    // Causes gathered from entry into reset until release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_r <= `FLAGS_RESET_VAL;
        end else if (state_r == ST_RUN) begin
            cause_r <= src_now;
        end else begin
            cause_r <= cause_r | src_now;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= `FLAGS_RESET_VAL;
        end else if (release_ev) begin
            flags_r <= cause_r;
        end
    end

    // --------------------------------------------------------------
    // Source arming
    // --------------------------------------------------------------
    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pready_r && pwrite && !pslverr_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_arm_r <= 1'b0;
            cnv_arm_r <= 1'b0;
            mcd_en_r <= 1'b0;
        end else if (wr_acc && paddr == `OFS_RESET_SOURCE) begin
            cmp_arm_r <= pwdata[`BIT_CMP_FLAG];
            cnv_arm_r <= pwdata[`BIT_CNV_FLAG];
            mcd_en_r <= pwdata[`BIT_MCD_FLAG];
        end
    end

    // --------------------------------------------------------------
    // Watchdog
    // --------------------------------------------------------------
    assign wdt_link.soft_rst = !sys_rst_n_r;
    assign wdt_link.restart = wr_acc && paddr == `OFS_WDT_CONTROL
        && pwdata[7:0] == `WDT_KEY_RESTART;
    assign wdt_link.disable_req = wr_acc && paddr == `OFS_WDT_CONTROL
        && pwdata[7:0] == `WDT_KEY_DISABLE;
    assign wdt_link.lock_req = wr_acc && paddr == `OFS_WDT_CONTROL
        && pwdata[7:0] == `WDT_KEY_LOCK;
    assign wdt_link.sel_wr = wr_acc && paddr == `OFS_WDT_CONTROL
        && !pwdata[`WDT_BIT_SEL_WR];
    assign wdt_link.sel_val = pwdata[2:0];

    watchdog_timer #(
        .SHIFT_BASE(WDT_SHIFT_BASE)
    ) u_wdt (
        .pclk(pclk),
        .presetn(presetn),
        .ctl(wdt_link.wdt)
    );

    always_comb begin
        wdt_rd = 8'h00;
        wdt_rd[2:0] = wdt_link.sel;
        wdt_rd[`WDT_BIT_LOCKED] = wdt_link.locked;
        wdt_rd[`WDT_BIT_ENABLED] = wdt_link.enabled;
    end

    // --------------------------------------------------------------
    // Interrupt status, clear and enable
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= 8'h00;
        end else begin
            // Set wins over a clear in the same cycle
            irq_stat_r <= (irq_stat_r & ~((wr_acc && paddr == `OFS_IRQ_CLEAR) ?
                pwdata[7:0] : 8'h00)) | (release_ev ? cause_r : 8'h00);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_r <= 8'h00;
        end else if (wr_acc && paddr == `OFS_IRQ_ENABLE) begin
            irq_en_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_stat_r & irq_en_r);
        end
    end

    // --------------------------------------------------------------
    // APB slave
    // --------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        addr_ok = 1'b1;
        unique case (paddr)
            `OFS_RESET_SOURCE: rd_mux[7:0] = flags_r;
            `OFS_WDT_CONTROL: rd_mux[7:0] = wdt_rd;
            `OFS_IRQ_STATUS: rd_mux[7:0] = irq_stat_r;
            `OFS_IRQ_CLEAR: rd_mux = 32'h0000_0000;
            `OFS_IRQ_ENABLE: rd_mux[7:0] = irq_en_r;
            default: addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else if (setup_ph) begin
            pready_r <= 1'b1;
            pslverr_r <= !addr_ok;
            prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    cmp_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == `OFS_RESET_SOURCE && pwdata[`BIT_CMP_FLAG] |=> cmp_arm_r)
        else $error("comparator reset not armed by write");

    cnv_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == `OFS_RESET_SOURCE && pwdata[`BIT_CNV_FLAG] |=> cnv_arm_r)
        else $error("conversion-start reset not armed by write");

    cmp_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        cmp_arm_r && !sync2_r[1] |=> !sys_rst_n_r)
        else $error("armed comparator low did not reset");

    cnv_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        cnv_arm_r && !sync2_r[2] ##1 cnv_arm_r && !sync2_r[2] |-> !sys_rst_n_r)
        else $error("released while conversion-start held low");

    flag_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(sys_rst_n_r) |-> flags_r[`BIT_CMP_FLAG] == $past(cause_r[`BIT_CMP_FLAG])
            && flags_r[`BIT_CNV_FLAG] == $past(cause_r[`BIT_CNV_FLAG]))
        else $error("reset cause flags wrong after release");

    wdt_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        wdt_link.overflow |=> !sys_rst_n_r ##[1:20] sys_rst_n_r)
        else $error("watchdog overflow reset missing or stuck");

    wdt_boot_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(sys_rst_n_r) |-> wdt_link.enabled && !wdt_link.locked
            && wdt_link.sel == `WDT_SEL_RESET)
        else $error("watchdog not at boot state after reset");

    stretch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(sys_rst_n_r) |-> $past(!pin_low, 12) && $past(!sys_rst_n_r, 12))
        else $error("reset stretched fewer than 12 cycles");

    pin_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        pin_low && state_r != ST_RUN ##1 !pin_low [*8] ##1 !pin_low [*8] |->
            !sys_rst_n_r || flags_r[`BIT_PIN_FLAG])
        else $error("pin reset flag not set on release");

    lock_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        wdt_link.locked && sys_rst_n_r |=> wdt_link.locked)
        else $error("watchdog lock lost without reset");

    wdt_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
        !wdt_link.enabled |=> !wdt_link.overflow)
        else $error("disabled watchdog overflowed");
endmodule : reset_source_ctrl

/* File: rtl/rst_params.svh */
// Constants for the reset-source and watchdog block
//
// Notes on behaviour
// - Writing one to bit 5 of reset_source_register arms the comparator reset.
// - Armed comparator resets the device while plus input is below minus input.
// - Comparator flag reads one after a comparator reset, zero after others.
// - Comparator, conversion-start and watchdog resets never touch the reset pin.
// - Writing one to bit 6 of reset_source_register arms the conversion-start reset.
// - Armed conversion-start input holds reset while low; level, not edge, sensitive.
// - Conversion-start flag reads one after its reset, zero after others.
// - Watchdog overflow resets the device; a software restart before overflow prevents it.
// - After every reset the watchdog runs enabled with its longest interval.
// - Software may disable or lock the watchdog; locked ignores disable requests.
// - A locked watchdog stays enabled until the next system reset.
// - Watchdog is a 21-bit system-clock counter timing restarts against a limit.
// - Reset holds at least 12 cycles after pin release; pin flag is bit 0.
// - Missing-clock detector, once enabled by writing one to bit 2 of reset_source_register, resets the device and sets flag bit 2.
`ifndef RST_PARAMS_SVH
`define RST_PARAMS_SVH

// --------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------
`define OFS_RESET_SOURCE 12'h000
`define OFS_WDT_CONTROL 12'h004
`define OFS_IRQ_STATUS 12'h008
`define OFS_IRQ_CLEAR 12'h00C
`define OFS_IRQ_ENABLE 12'h010

// --------------------------------------------------------------
// Reset source field positions
// --------------------------------------------------------------
`define BIT_PIN_FLAG 0
`define BIT_MCD_FLAG 2
`define BIT_WDT_FLAG 3
`define BIT_CMP_FLAG 5
`define BIT_CNV_FLAG 6

// --------------------------------------------------------------
// Watchdog control fields and keys
// --------------------------------------------------------------
`define WDT_BIT_SEL_WR 7
`define WDT_KEY_RESTART 8'hA5
`define WDT_KEY_DISABLE 8'hDE
`define WDT_KEY_LOCK 8'hFF
`define WDT_BIT_ENABLED 4
`define WDT_BIT_LOCKED 3
`define WDT_SEL_RESET 3'h7
`define WDT_WIDTH 21
`define WDT_SHIFT_BASE 14

// --------------------------------------------------------------
// Reset values and timing
// --------------------------------------------------------------
`define SYNC_RESET_VAL 4'h7
`define FLAGS_RESET_VAL 8'h00
`define CLK_PERIOD_NS 10
`define MCD_TIMEOUT_US 100
`define RST_STRETCH_CYC 12

`endif

/* File: rtl/rst_pkg.sv */
// Types for the reset-source and watchdog block
package rst_pkg;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_HOLD = 2'b01,
        ST_STRETCH = 2'b10
    } seq_state_type;
endpackage : rst_pkg

/* File: rtl/wdt_if.sv */
// Control and status link between reset controller and watchdog
`timescale 1ns/1ns
interface wdt_if;
    logic soft_rst;
    logic restart;
    logic disable_req;
    logic lock_req;
    logic sel_wr;
    logic [2:0] sel_val;
    logic enabled;
    logic locked;
    logic [2:0] sel;
    logic overflow;
    modport ctrl (output soft_rst, restart, disable_req, lock_req, sel_wr, sel_val,
                  input enabled, locked, sel, overflow);
    modport wdt (input soft_rst, restart, disable_req, lock_req, sel_wr, sel_val,
                 output enabled, locked, sel, overflow);
endinterface : wdt_if

/* File: rtl/watchdog_timer.sv */
// Watchdog counter with enable, lock and interval select
`timescale 1ns/1ns
`include "rst_params.svh"
module watchdog_timer import rst_pkg::*; #(
    parameter int unsigned SHIFT_BASE = `WDT_SHIFT_BASE
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control link
    wdt_if.wdt ctl
);
    logic [`WDT_WIDTH-1:0] count_r;
    logic [`WDT_WIDTH-1:0] limit_m1;
    logic [`WDT_WIDTH:0] limit_full;
    logic en_r;
    logic lock_r;
    logic [2:0] sel_r;
    logic ovf_r;

    assign limit_full = (`WDT_WIDTH+1)'(1) << (SHIFT_BASE + 32'(sel_r));
    assign limit_m1 = `WDT_WIDTH'(limit_full - (`WDT_WIDTH+1)'(1));
    assign ctl.enabled = en_r;
    assign ctl.locked = lock_r;
    assign ctl.sel = sel_r;
    assign ctl.overflow = ovf_r;

    // --------------------------------------------------------------
    // Enable, lock and interval
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= 1'b1;
            lock_r <= 1'b0;
            sel_r <= `WDT_SEL_RESET;
        end else if (ctl.soft_rst) begin
            en_r <= 1'b1;
            lock_r <= 1'b0;
            sel_r <= `WDT_SEL_RESET;
        end else begin
            if (ctl.lock_req) begin
                lock_r <= 1'b1;
                en_r <= 1'b1;
            end else if (ctl.disable_req && !lock_r) begin
                en_r <= 1'b0;
            end else if (ctl.restart) begin
                en_r <= 1'b1;
            end
            if (ctl.sel_wr) begin
                sel_r <= ctl.sel_val;
            end
        end
    end

    // --------------------------------------------------------------
    // Counter and overflow
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= '0;
            ovf_r <= 1'b0;
        end else if (ctl.soft_rst || ctl.restart || !en_r) begin
            count_r <= '0;
            ovf_r <= 1'b0;
        end else if (count_r == limit_m1) begin
            count_r <= '0;
            ovf_r <= 1'b1;
        end else begin
            count_r <= count_r + `WDT_WIDTH'(1);
            ovf_r <= 1'b0;
        end
    end

    wdt_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
        lock_r && ctl.disable_req && !ctl.soft_rst |=> en_r && lock_r)
        else $error("locked watchdog was disabled");
endmodule : watchdog_timer

/* File: sim/source_model.sv */
// Comparator output and routed conversion-start pin model
`timescale 1ns/1ns
module source_model (
    // Clock
    input wire logic pclk,
    // Requests from the bench
    input wire logic cmp_below,
    input wire logic cnv_low,
    // Levels toward the block
    output logic comparator_out,
    output logic conversion_start_input
);
    // ----------------------------------------------------------
    // Idle high, low only on request
    // ----------------------------------------------------------
    always @(posedge pclk) begin
        comparator_out <= !cmp_below;
        conversion_start_input <= !cnv_low;
    end
endmodule : source_model

/* File: sim/tb_reset_source_and_watchdog.sv */
// Testbench for the reset-source and watchdog block
`timescale 1ns/1ns
`include "rst_params.svh"
module tb_reset_source_and_watchdog;
    // ----------------------------------------------------------
    // Signals
    // ----------------------------------------------------------
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, sys_reset_n, irq, comparator_out, conversion_start_input, er;
    logic ext_reset_n = 1'b1, missing_clock_in = 1'b0, cmp_below = 1'b0, cnv_low = 1'b0;
    int n_mismatch = 0, n_tests = 0, n_rst = 0, c, n;

    always #5 pclk = ~pclk;
    always @(negedge sys_reset_n) n_rst++;

    reset_source_ctrl #(.WDT_SHIFT_BASE(2)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_reset_n(ext_reset_n),
        .comparator_out(comparator_out), .conversion_start_input(conversion_start_input),
        .missing_clock_in(missing_clock_in), .sys_reset_n(sys_reset_n), .irq(irq));
    source_model model_u (.pclk(pclk), .cmp_below(cmp_below), .cnv_low(cnv_low),
        .comparator_out(comparator_out), .conversion_start_input(conversion_start_input));

    // ----------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) chk("pready", 1, 0);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdchk
    task automatic wait_lvl(input logic v, input int mx, output int k);
        for (k = 0; k < mx; k++) begin
            @(negedge pclk);
            if (sys_reset_n === v) break;
        end
        if (k >= mx) chk("sys_reset_n", v, ~v);
    endtask : wait_lvl
    task automatic idle(input int k);
        repeat (k) @(posedge pclk);
    endtask : idle

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_pin;
        @(posedge pclk) ext_reset_n <= 1'b0;
        wait_lvl(0, 10, c);
        idle(5);
        ext_reset_n <= 1'b0;
        @(posedge pclk) ext_reset_n <= 1'b1;
        wait_lvl(1, 60, c);
        chk("stretch", 1, c >= 14);
        rdchk("flags", `OFS_RESET_SOURCE, 32'h01);
        rdchk("status", `OFS_IRQ_STATUS, 32'h01);
        wr(`OFS_IRQ_ENABLE, 32'h01);
        idle(3);
        chk("irq", 1, irq);
        wr(`OFS_IRQ_CLEAR, 32'h01);
        idle(3);
        chk("irq", 0, irq);
    endtask : t_pin
    task automatic t_cmp;
        n = n_rst;
        @(posedge pclk) cmp_below <= 1'b1;
        idle(8);
        cmp_below <= 1'b0;
        idle(4);
        chk("unarmed", n, n_rst);
        wr(`OFS_RESET_SOURCE, 32'h20);
        @(posedge pclk) cmp_below <= 1'b1;
        wait_lvl(0, 6, c);
        idle(4);
        cmp_below <= 1'b0;
        wait_lvl(1, 40, c);
        rdchk("flags", `OFS_RESET_SOURCE, 32'h20);
    endtask : t_cmp
    task automatic t_cnv;
        wr(`OFS_RESET_SOURCE, 32'h40);
        @(posedge pclk) cnv_low <= 1'b1;
        wait_lvl(0, 6, c);
        n = 0;
        repeat (40) begin
            @(negedge pclk);
            if (sys_reset_n !== 1'b0) n++;
        end
        chk("held", 0, n);
        @(posedge pclk) cnv_low <= 1'b0;
        wait_lvl(1, 40, c);
        rdchk("flags", `OFS_RESET_SOURCE, 32'h40);
    endtask : t_cnv
    task automatic t_mcd;
        wr(`OFS_RESET_SOURCE, 32'h04);
        @(posedge pclk) missing_clock_in <= 1'b1;
        idle(3);
        missing_clock_in <= 1'b0;
        wait_lvl(0, 8, c);
        wait_lvl(1, 40, c);
        rdchk("flags", `OFS_RESET_SOURCE, 32'h04);
    endtask : t_mcd
    task automatic t_wdt;
        n = n_rst;
        wr(`OFS_WDT_CONTROL, 32'hA5);
        wr(`OFS_WDT_CONTROL, 32'h03);
        repeat (8) begin
            wr(`OFS_WDT_CONTROL, 32'hA5);
            idle(10);
        end
        chk("resets", n, n_rst);
        rdchk("wdt", `OFS_WDT_CONTROL, 32'h13);
        wait_lvl(0, 100, c);
        wait_lvl(1, 40, c);
        rdchk("flags", `OFS_RESET_SOURCE, 32'h08);
        rdchk("wdt", `OFS_WDT_CONTROL, 32'h17);
        wr(`OFS_WDT_CONTROL, 32'hDE);
        rdchk("wdt", `OFS_WDT_CONTROL, 32'h07);
        n = n_rst;
        idle(700);
        chk("resets", n, n_rst);
        wr(`OFS_WDT_CONTROL, 32'hA5);
        wr(`OFS_WDT_CONTROL, 32'hFF);
        wr(`OFS_WDT_CONTROL, 32'hDE);
        rdchk("wdt", `OFS_WDT_CONTROL, 32'h1F);
        wait_lvl(0, 600, c);
        wait_lvl(1, 40, c);
        rdchk("wdt", `OFS_WDT_CONTROL, 32'h17);
    endtask : t_wdt
    task automatic t_bus;
        apb(1'b0, 12'h0FC, 32'h0);
        chk("pslverr", 1, er);
        chk("prdata", 0, rd);
        wr(`OFS_IRQ_STATUS, 32'hFF);
        rdchk("status", `OFS_IRQ_STATUS, 32'h6C);
        wr(`OFS_IRQ_CLEAR, 32'hFF);
        rdchk("status", `OFS_IRQ_STATUS, 32'h00);
    endtask : t_bus

    // ----------------------------------------------------------
    // Sequence and verdict
    // ----------------------------------------------------------
    task automatic test_done;
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    initial begin
        idle(20);
        presetn <= 1'b1;
        wait_lvl(1, 40, c);
        rdchk("wdt", `OFS_WDT_CONTROL, 32'h17);
        rdchk("flags", `OFS_RESET_SOURCE, 32'h00);
        t_pin();
        t_cmp();
        t_cnv();
        t_mcd();
        t_wdt();
        t_bus();
        test_done();
    end
    initial begin
        #600000;
        n_mismatch++;
        test_done();
    end
endmodule : tb_reset_source_and_watchdog
